// ---- inc/ivc_consts.vh ----
`ifndef IVC_CONSTS_VH
`define IVC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IVC_OFF_CTRL      4'h0
`define IVC_OFF_COUNT     4'h4
`define IVC_OFF_STATUS    4'h8
`define IVC_OFF_VALUE     4'hc

// ****************************************************************
// Control word fields
// ****************************************************************
`define IVC_CTRL_MODE_LSB 0
`define IVC_CTRL_MODE_MSB 2
`define IVC_CTRL_BCD_BIT  3

// ****************************************************************
// Status word fields
// ****************************************************************
`define IVC_ST_OUT_BIT    0
`define IVC_ST_RUN_BIT    1
`define IVC_ST_NULL_BIT   2
`define IVC_ST_LOAD_BIT   3

// ****************************************************************
// Mode codes
// ****************************************************************
`define IVC_MODE0         3'h0
`define IVC_MODE1         3'h1
`define IVC_MODE2         3'h2
`define IVC_MODE3         3'h3
`define IVC_MODE4         3'h4
`define IVC_MODE5         3'h5

// ****************************************************************
// Reset values and count constants
// ****************************************************************
`define IVC_MODE_RESET    3'h0
`define IVC_CR_RESET      16'h0000
`define IVC_CE_RESET      16'h0000
`define IVC_CE_ONE        16'h0001
`define IVC_CE_TWO        16'h0002
`define IVC_CE_ZERO       16'h0000
`define IVC_RD_ZERO       32'h00000000

`endif

// ---- design/pin_sync_edge.v ----
`default_nettype none

// Two-stage synchroniser with edge pulses taken from the second stage
module pin_sync_edge (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;

endmodule // pin_sync_edge

`default_nettype wire

// ---- design/count_decrement.v ----
`default_nettype none

// Next value of the counting element, binary or four decimal digits
module count_decrement (
  input  wire        bcd_i,
  input  wire        by_two_i,
  input  wire [15:0] value_i,
  output wire [15:0] result_o
);

  // Digit-wise borrow; 0000 wraps to 9999
  function [15:0] bcd_minus_one;
    input [15:0] v;
    integer      i;
    reg          borrow;
    reg [3:0]    d;
    begin
      borrow        = 1'b1;
      bcd_minus_one = v;
      for (i = 0; i < 4; i = i + 1) begin
        d = v[i*4 +: 4];
        if (borrow) begin
          if (d == 4'h0) begin
            bcd_minus_one[i*4 +: 4] = 4'h9;
          end else begin
            bcd_minus_one[i*4 +: 4] = d - 4'h1;
            borrow                  = 1'b0;
          end
        end
      end
    end
  endfunction

  wire [15:0] bin_one;
  wire [15:0] bin_two;
  wire [15:0] bcd_one;
  wire [15:0] bcd_two;

  // RQ20 modulo decrement
  assign bin_one  = value_i - 16'h0001;
  assign bin_two  = value_i - 16'h0002;
  assign bcd_one  = bcd_minus_one(value_i);
  assign bcd_two  = bcd_minus_one(bcd_one);
  // RQ15 wrap past zero
  assign result_o = bcd_i ? (by_two_i ? bcd_two : bcd_one)
                          : (by_two_i ? bin_two : bin_one);

endmodule // count_decrement

`default_nettype wire

// ---- design/interval_counter_channel.v ----
// Overview of operation
// RQ1 - Mode 5: output high, waits gate rise
// RQ2 - Mode 5: expiry strobes output low one pulse
// RQ3 - Mode 5: trigger pulse loads, no decrement
// RQ4 - Mode 5: every trigger reloads and restarts
// RQ5 - Mode 5: gate level never touches output
// RQ6 - Mode 5: new count waits for trigger
// RQ7 - Mode 1: gate rise starts, output low
// RQ8 - Modes 2,3: gate low stops, output high
// RQ9 - Host keeps counts at legal minimums
// RQ10 - Count zero means largest count
// RQ11 - Control write resets channel at once
// RQ12 - Gate level sampled at count clock rise
// RQ13 - Gate rise flag caught, cleared after sampling
// RQ14 - Load and decrement on falling edge
// RQ15 - Modes 0,1,4,5 wrap past zero
// RQ16 - Modes 2,3 reload themselves each period
// RQ17 - Host pulses gate after new count
// RQ18 - Count pulse is rise then fall
// RQ19 - Loading copies holding register to element
// RQ20 - Sixteen-bit element, binary or decimal digits

`include "ivc_consts.vh"

`default_nettype none

module interval_counter_channel (
  input  wire        clk_i,
  input  wire        rst_i,
  // Avalon-MM slave
  input  wire [3:0]  address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [31:0] writedata_i,
  input  wire [3:0]  byteenable_i,
  output reg  [31:0] readdata_o,
  output wire        waitrequest_o,
  // Channel pins
  input  wire        count_clk_i,
  input  wire        gate_i,
  output wire        out_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire cclk_rise;
  wire cclk_fall;
  wire gate_s;
  wire gate_rise;

  // RQ18 pulse edges
  pin_sync_edge u_cclk_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (count_clk_i),
    .level_o (),
    .rise_o  (cclk_rise),
    .fall_o  (cclk_fall)
  );

  pin_sync_edge u_gate_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (gate_i),
    .level_o (gate_s),
    .rise_o  (gate_rise),
    .fall_o  ()
  );

  // ****************************************************************
  // Channel state
  // ****************************************************************
  reg  [2:0]  mode_q;
  reg         bcd_q;
  reg  [15:0] cr_q;
  reg  [15:0] ce_q;
  reg         out_q;
  reg         run_q;
  reg         load_q;
  reg         have_cr_q;
  reg         strobe_q;
  reg         ext_q;
  reg         trig_q;
  reg         trig_smp_q;
  reg         gate_smp_q;
  reg         ack_q;

  // ****************************************************************
  // Mode decoding
  // ****************************************************************
  function is_edge_mode;
    input [2:0] m;
    begin
      is_edge_mode = (m == `IVC_MODE1) || (m == `IVC_MODE2) ||
                     (m == `IVC_MODE3) || (m == `IVC_MODE5);
    end
  endfunction

  function is_level_mode;
    input [2:0] m;
    begin
      is_level_mode = (m == `IVC_MODE0) || (m == `IVC_MODE2) ||
                      (m == `IVC_MODE3) || (m == `IVC_MODE4);
    end
  endfunction

  function is_periodic;
    input [2:0] m;
    begin
      is_periodic = (m == `IVC_MODE2) || (m == `IVC_MODE3);
    end
  endfunction

  // Codes 6 and 7 fold onto the periodic modes
  function [2:0] fold_mode;
    input [2:0] m;
    begin
      if (m[2] && m[1]) begin
        fold_mode = {1'b0, m[1:0]};
      end else begin
        fold_mode = m;
      end
    end
  endfunction

  // ****************************************************************
  // Counting element arithmetic
  // ****************************************************************
  wire [15:0] ce_next;
  wire [15:0] cr_even;
  wire        count_en;

  count_decrement u_dec (
    .bcd_i    (bcd_q),
    .by_two_i (mode_q == `IVC_MODE3),
    .value_i  (ce_q),
    .result_o (ce_next)
  );

  // Square wave counts down by two from an even start
  assign cr_even  = {cr_q[15:1], 1'b0};
  // RQ12 level gating
  assign count_en = is_level_mode(mode_q) ? gate_smp_q : 1'b1;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  wire        req;
  wire        wr_take;
  wire        wr_ctrl;
  wire        wr_count;
  wire [15:0] cr_merged;

  // One wait cycle per access; read data is ready when it drops
  assign req           = read_i | write_i;
  assign waitrequest_o = req & ~ack_q;
  assign wr_take       = write_i & ack_q;
  assign wr_ctrl       = wr_take & (address_i == `IVC_OFF_CTRL) & byteenable_i[0];
  assign wr_count      = wr_take & (address_i == `IVC_OFF_COUNT) &
                         (byteenable_i[0] | byteenable_i[1]);
  assign cr_merged     = {byteenable_i[1] ? writedata_i[15:8] : cr_q[15:8],
                          byteenable_i[0] ? writedata_i[7:0]  : cr_q[7:0]};

  reg [31:0] rd_d;

  always @* begin
    rd_d = `IVC_RD_ZERO;
    if (address_i == `IVC_OFF_CTRL) begin
      rd_d[`IVC_CTRL_MODE_MSB:`IVC_CTRL_MODE_LSB] = mode_q;
      rd_d[`IVC_CTRL_BCD_BIT]                     = bcd_q;
    end else if (address_i == `IVC_OFF_COUNT) begin
      rd_d[15:0] = cr_q;
    end else if (address_i == `IVC_OFF_STATUS) begin
      rd_d[`IVC_ST_OUT_BIT]  = out_q;
      rd_d[`IVC_ST_RUN_BIT]  = run_q;
      rd_d[`IVC_ST_NULL_BIT] = ~have_cr_q;
      rd_d[`IVC_ST_LOAD_BIT] = load_q;
    end else if (address_i == `IVC_OFF_VALUE) begin
      rd_d[15:0] = ce_q;
    end else begin
      rd_d = `IVC_RD_ZERO;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q      <= 1'b0;
      readdata_o <= `IVC_RD_ZERO;
    end else begin
      ack_q <= req & ~ack_q;
      if (read_i & ~ack_q) begin
        readdata_o <= rd_d;
      end
    end
  end

  // ****************************************************************
  // Gate sampling and trigger flag
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_q     <= 1'b0;
      trig_smp_q <= 1'b0;
      gate_smp_q <= 1'b0;
    end else begin
      // RQ13 set wins over clear
      if (gate_rise & is_edge_mode(mode_q)) begin
        trig_q <= 1'b1;
      end else if (cclk_rise | wr_ctrl) begin
        trig_q <= 1'b0;
      end
      // RQ12 sample at rise
      if (cclk_rise) begin
        gate_smp_q <= gate_s;
        trig_smp_q <= trig_q & have_cr_q & ~wr_ctrl;
      end else if (wr_ctrl) begin
        trig_smp_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Counting element and output
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q    <= `IVC_MODE_RESET;
      bcd_q     <= 1'b0;
      cr_q      <= `IVC_CR_RESET;
      ce_q      <= `IVC_CE_RESET;
      out_q     <= 1'b0;
      run_q     <= 1'b0;
      load_q    <= 1'b0;
      have_cr_q <= 1'b0;
      strobe_q  <= 1'b0;
      ext_q     <= 1'b0;
    end else if (wr_ctrl) begin
      // RQ11 immediate channel reset
      mode_q    <= fold_mode(writedata_i[`IVC_CTRL_MODE_MSB:`IVC_CTRL_MODE_LSB]);
      bcd_q     <= writedata_i[`IVC_CTRL_BCD_BIT];
      // RQ1 initial level
      out_q     <= (fold_mode(writedata_i[`IVC_CTRL_MODE_MSB:`IVC_CTRL_MODE_LSB])
                    != `IVC_MODE0);
      run_q     <= 1'b0;
      load_q    <= 1'b0;
      have_cr_q <= 1'b0;
      strobe_q  <= 1'b0;
      ext_q     <= 1'b0;
    end else begin
      if (wr_count) begin
        cr_q      <= cr_merged;
        have_cr_q <= 1'b1;
        if ((mode_q == `IVC_MODE0) || (mode_q == `IVC_MODE4)) begin
          load_q <= 1'b1;
        end else if (is_periodic(mode_q) && !have_cr_q) begin
          load_q <= 1'b1;
        end
        if (mode_q == `IVC_MODE0) begin
          out_q <= 1'b0;
        end
      end
      // RQ14 falling edge work
      if (cclk_fall) begin
        // RQ2 strobe lasts one pulse
        if (((mode_q == `IVC_MODE4) || (mode_q == `IVC_MODE5)) && !out_q) begin
          out_q <= 1'b1;
        end
        case (mode_q)
          `IVC_MODE0: begin
            if (load_q && !wr_count) begin
              // RQ19 copy holding register
              ce_q   <= cr_q;
              load_q <= 1'b0;
              run_q  <= 1'b1;
            end else if (run_q && count_en) begin
              // RQ15 wraps
              ce_q <= ce_next;
              if (ce_q == `IVC_CE_ONE) begin
                out_q <= 1'b1;
              end
            end
          end
          `IVC_MODE1: begin
            if (trig_smp_q) begin
              // RQ7 low after next pulse
              ce_q     <= cr_q;
              out_q    <= 1'b0;
              run_q    <= 1'b1;
              strobe_q <= 1'b1;
            end else if (run_q) begin
              ce_q <= ce_next;
              if ((ce_q == `IVC_CE_ONE) && strobe_q) begin
                out_q    <= 1'b1;
                strobe_q <= 1'b0;
              end
            end
          end
          `IVC_MODE2: begin
            if ((load_q && !wr_count) || trig_smp_q) begin
              ce_q   <= cr_q;
              load_q <= 1'b0;
              run_q  <= 1'b1;
            end else if (run_q && count_en) begin
              if (ce_q == `IVC_CE_ONE) begin
                // RQ16 self reload
                ce_q  <= cr_q;
                out_q <= 1'b1;
              end else begin
                ce_q <= ce_next;
                if (ce_q == `IVC_CE_TWO) begin
                  out_q <= 1'b0;
                end
              end
            end
          end
          `IVC_MODE3: begin
            if ((load_q && !wr_count) || trig_smp_q) begin
              ce_q   <= cr_even;
              load_q <= 1'b0;
              run_q  <= 1'b1;
              ext_q  <= 1'b0;
            end else if (run_q && count_en) begin
              if (ext_q) begin
                // Odd counts hold the high half one pulse longer
                ext_q <= 1'b0;
                out_q <= 1'b0;
                ce_q  <= cr_even;
              end else if (ce_q == `IVC_CE_TWO) begin
                if (cr_q[0] && out_q) begin
                  ext_q <= 1'b1;
                  ce_q  <= `IVC_CE_ZERO;
                end else begin
                  // RQ16 half-period reload
                  out_q <= ~out_q;
                  ce_q  <= cr_even;
                end
              end else begin
                ce_q <= ce_next;
              end
            end
          end
          `IVC_MODE4: begin
            if (load_q && !wr_count) begin
              ce_q     <= cr_q;
              load_q   <= 1'b0;
              run_q    <= 1'b1;
              strobe_q <= 1'b1;
            end else if (run_q && count_en) begin
              ce_q <= ce_next;
              if ((ce_q == `IVC_CE_ONE) && strobe_q) begin
                out_q    <= 1'b0;
                strobe_q <= 1'b0;
              end
            end
          end
          `IVC_MODE5: begin
            // RQ5 gate only acts through triggers
            if (trig_smp_q) begin
              // RQ3 load pulse, no decrement
              // RQ4 retrigger reloads
              // RQ6 picks up newest count
              ce_q     <= cr_q;
              run_q    <= 1'b1;
              strobe_q <= 1'b1;
            end else if (run_q) begin
              // RQ10 zero runs full range
              ce_q <= ce_next;
              if ((ce_q == `IVC_CE_ONE) && strobe_q) begin
                // RQ2 one strobe per trigger
                out_q    <= 1'b0;
                strobe_q <= 1'b0;
              end
            end
          end
          default: begin
            run_q <= 1'b0;
          end
        endcase
      end
      // RQ8 gate low forces high
      if (is_periodic(mode_q) && !gate_s) begin
        out_q <= 1'b1;
      end
    end
  end

  assign out_o = out_q;

endmodule // interval_counter_channel

`default_nettype wire

// ---- tb/ivc_properties.sv ----
`default_nettype none
// *****
// Bus and output checks
// *****
module ivc_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        count_clk_i,
  input wire logic        gate_i,
  input wire logic        out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] since_fall_q;
  logic       ack;
  logic       ctl;
  logic       wacc;
  assign ack = (read_i | write_i) & ~waitrequest_o;
  assign wacc = ack & write_i;
  assign ctl = ack & write_i & (address_i == 4'h0) & byteenable_i[0];
  // Saturates so a stopped count clock never wraps
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) since_fall_q <= 4'hf;
    else if ($fell(count_clk_i)) since_fall_q <= 4'h0;
    else if (since_fall_q != 4'hf) since_fall_q <= since_fall_q + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wait_one:
    assert property ($rose(read_i | write_i) |-> waitrequest_o ##1 !waitrequest_o)
      else $error("waitrequest not low after one cycle");
  a_wait_idle:
    assert property (!(read_i | write_i) |-> !waitrequest_o)
      else $error("waitrequest high while idle");
  a_mode5_high:
    assert property (ctl && writedata_i[2:0] == 3'h5 |=> out_o)
      else $error("out not high after mode 5 control");
  a_mode0_low:
    assert property (ctl && writedata_i[2:0] == 3'h0 |=> !out_o)
      else $error("out not low after mode 0 control");
  a_strobe_width:
    assert property ($fell(out_o) |-> !out_o [*8])
      else $error("out low shorter than a count pulse");
  a_out_cause:
    assert property ($changed(out_o) |-> since_fall_q <= 4'h6 || $past(wacc) ||
                     ($past(gate_i, 4) && !$past(gate_i, 3)))
      else $error("out moved without count fall, write or gate fall");
  a_unmapped_zero:
    assert property (ack && read_i && address_i[1:0] != 2'h0 |-> readdata_o == 32'h0)
      else $error("unmapped read not zero");
  a_status_out:
    assert property (ack && read_i && address_i == 4'h8 |-> readdata_o[0] == $past(out_o))
      else $error("status out bit differs from out");
  a_read_stable:
    assert property (!read_i |=> $stable(readdata_o))
      else $error("readdata moved without a read");
endmodule // ivc_properties
`default_nettype wire

// ---- tb/count_clk_source.sv ----
`default_nettype none
// *****
// Count clock source
// *****
module count_clk_source (
  input  wire logic clk_i,
  input  wire logic run_i,
  output var  logic count_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial count_clk_o = 1'b0;
  // rise then fall
  // Stands low between bursts; halves kept above sync limit
  always begin
    if (run_i === 1'b1) begin
      @(posedge clk_i);
      count_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      count_clk_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end else begin
      @(posedge clk_i);
    end
  end
endmodule // count_clk_source
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
// *****
// Channel bench
// *****
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  address_i = 4'h0;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0]  byteenable_i = 4'h0;
  logic        gate_i = 1'b0;
  logic        run = 1'b0;
  wire  [31:0] readdata_o;
  wire         waitrequest_o;
  wire         count_clk_i;
  wire         out_o;
  logic [31:0] exp_rd [$];
  int          lead_q [$];
  int          width_q [$];
  int          falls = 0;
  int          low_at = 0;
  int          width = 0;
  bit          in_strobe = 1'b0;
  int          miscompares = 0;
  int          check_count = 0;
  integer      seed = 32'hf5657050;
  always #20 clk_i = ~clk_i;
  interval_counter_channel i_interval_counter_channel (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .count_clk_i(count_clk_i), .gate_i(gate_i), .out_o(out_o));
  count_clk_source i_count_clk_source (
    .clk_i(clk_i), .run_i(run), .count_clk_o(count_clk_i));
  task automatic check_data(input string name, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic check_pulses(input string name, input int e, input int s);
    check_count++;
    if (s != e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic rd, input logic [3:0] addr, input logic [31:0] data);
    int k;
    @(posedge clk_i);
    address_i <= addr;
    writedata_i <= data;
    byteenable_i <= 4'hf;
    read_i <= rd;
    write_i <= !rd;
    // Released only after the edge that saw waitrequest low
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (waitrequest_o === 1'b0) break;
    end
    if (k == 20) begin
      miscompares++;
      report_and_stop();
    end
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    bus(1'b0, addr, data);
  endtask
  task automatic rd(input logic [3:0] addr, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b1, addr, 32'h0);
  endtask
  // Short gate pulse; lead 0 means no strobe expected
  task automatic trigger(input int lead, input int wid);
    if (lead > 0) begin
      lead_q.push_back(lead);
      width_q.push_back(wid);
    end
    @(posedge clk_i);
    gate_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    gate_i <= 1'b0;
  endtask
  // Settling wait covers the pin synchroniser delay
  task automatic run_pulses(input int k);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (k) @(negedge count_clk_i);
    run <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (read_i && waitrequest_o === 1'b0 && exp_rd.size() > 0) begin
      check_data("readdata", exp_rd.pop_front(), readdata_o);
    end
  end
  always @(negedge count_clk_i) falls++;
  always @(posedge gate_i) falls = 0;
  always @(negedge out_o) begin
    if (rst_i === 1'b0) begin
      if (lead_q.size() == 0) begin
        check_pulses("unexpected strobe", 0, 1);
      end else begin
        check_pulses("strobe lead", lead_q.pop_front(), falls);
        width = width_q.pop_front();
        low_at = falls;
        in_strobe = 1'b1;
      end
    end
  end
  always @(posedge out_o) begin
    if (in_strobe) check_pulses("strobe width", width, falls - low_at);
    in_strobe = 1'b0;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
  initial begin
    int i;
    int n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(4'h0, 32'h0);
    rd(4'h8, 32'h4);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'h2);
    run_pulses(3);
    rd(4'hc, 32'h2);
    @(posedge clk_i);
    gate_i <= 1'b1;
    run_pulses(2);
    rd(4'h8, 32'h3);
    @(posedge clk_i);
    gate_i <= 1'b0;
    wr(4'h0, 32'h5);
    rd(4'h8, 32'h5);
    wr(4'h4, 32'h3);
    run_pulses(3);
    trigger(4, 1);
    run_pulses(5);
    rd(4'hc, 32'hffff);
    trigger(0, 0);
    run_pulses(2);
    wr(4'h4, 32'h5);
    trigger(6, 1);
    run_pulses(8);
    trigger(6, 1);
    run_pulses(2);
    wr(4'h4, 32'h2);
    run_pulses(6);
    // Second strobe is cut short by the gate, so zero pulses wide
    wr(4'h0, 32'h2);
    wr(4'h4, 32'h3);
    lead_q.push_back(3);
    width_q.push_back(1);
    lead_q.push_back(6);
    width_q.push_back(0);
    @(posedge clk_i);
    gate_i <= 1'b1;
    run_pulses(6);
    @(posedge clk_i);
    gate_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (i = 3; i < 5; i++) begin
      wr(4'h0, 32'(i));
      wr(4'h4, i[0] ? 32'h4 : 32'h2);
      lead_q.push_back(3);
      width_q.push_back(i[0] ? 2 : 1);
      @(posedge clk_i);
      gate_i <= 1'b1;
      run_pulses(5);
      @(posedge clk_i);
      gate_i <= 1'b0;
    end
    for (i = 0; i < 6; i++) begin
      n = 1 + {$random(seed)} % 6;
      wr(4'h0, i[0] ? 32'h1 : 32'h5);
      wr(4'h4, 32'(n));
      if (i[0]) trigger(1, n);
      else trigger(n + 1, 1);
      run_pulses(n + 3);
    end
    for (i = 0; i < 2; i++) begin
      wr(4'h0, i[0] ? 32'hd : 32'h5);
      wr(4'h4, 32'h0);
      trigger(0, 0);
      run_pulses(2);
      rd(4'hc, i[0] ? 32'h9999 : 32'hffff);
    end
    report_and_stop();
  end
endmodule // tb_top
bind interval_counter_channel ivc_properties i_ivc_properties (
  .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .count_clk_i(count_clk_i), .gate_i(gate_i), .out_o(out_o));
`default_nettype wire
